// *** rtl/cgpt_core_timer.sv ***
/*
 Core 16-bit general purpose timer with direction control, prescaled
 timer mode, gated timer mode, edge counter mode and overflow toggle latch.
 Assumes external lines are synchronous-enough levels held >= 4 clocks;
 auxiliary timers are outside and reuse the direction helper and link.
*/
// Summary of operation
// - External direction off: software bit selects up (0) or down (1).
// - External direction on: low line counts up; software bit inverts sense.
// - Direction changes apply immediately, running or stopped.
// - Auxiliary timers reuse the same direction scheme with their own bits.
// - Each overflow or underflow toggles the toggle latch.
// - Software may force the toggle latch to 0 or 1.
// - Output enable drives the latch onto the toggle output line.
// - Latch goes internally to auxiliary timers, independent of output enable.
// - Mode 000 counts module clock divided by selected prescaler.
// - Prescale is 4 when fast, else base 8 times two to input select; 4 to 1024.
// - Same prescaler applies to gated mode and auxiliary timers.
// - Modes 010 and 011 gate on low or high timer input.
// - Gated mode advances only when run set and gate active.
// - Gate transitions raise no interrupt request.
// - Mode 001 counts selected input edges; none, rise, fall, both.
// - Run bit starts and stops timer and remote-run auxiliary timers.
// - CPU write wins over a simultaneous count update.
// - Counter is 16-bit, readable and writable at any time.
`timescale 1ns/1ns
module cgpt_core_timer #(
   parameter int CNT_W = cgpt_pkg::CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control bits
   input wire cgpt_pkg::cgpt_ctrl_t ctrl,
   // CPU writes to the counter and toggle latch
   input wire cgpt_pkg::cgpt_wr_t cnt_wr,
   input wire logic tog_wr,
   input wire logic tog_wr_val,
   // External lines
   input wire logic timer_input_line,
   input wire logic ext_updown_line,
   // Auxiliary remote run options
   input wire logic first_aux_remote_run,
   input wire logic second_aux_remote_run,
   // Counter state and status
   output logic [CNT_W-1:0] count,
   output cgpt_pkg::cgpt_stat_t stat,
   // Toggle output and internal links
   output logic toggle_output_line,
   output logic aux_toggle_link,
   output logic first_aux_run,
   output logic second_aux_run
);
   // Direction rule shared with the auxiliary timers
   // shared direction scheme
   function automatic logic dir_down(input logic sw_dir, input logic ext_en, input logic ext_line);
      dir_down = ext_en ? (ext_line ^ sw_dir) : sw_dir;
   endfunction

   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic [1:0] next_sync_a;
   logic [1:0] next_sync_b;
   logic in_prev;
   logic next_in_prev;
   logic in_s;
   logic ud_s;
   logic [cgpt_pkg::PRESC_W-1:0] presc;
   logic [cgpt_pkg::PRESC_W-1:0] next_presc;
   logic [CNT_W-1:0] next_count;
   logic toggle;
   logic next_toggle;
   logic down;
   logic tick;
   logic step;
   logic wrap;
   logic gate_ok;
   logic edge_hit;
   logic [cgpt_pkg::PRESC_W-1:0] presc_last;

   // Synchroniser and edge history next values
   always_comb begin
      next_sync_a = {sync_a[0], timer_input_line};
      next_sync_b = {sync_b[0], ext_updown_line};
      next_in_prev = sync_a[1];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
         in_prev <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         in_prev <= next_in_prev;
      end
   end

   assign in_s = sync_a[1];
   assign ud_s = sync_b[1];

   assign down = dir_down(ctrl.sw_dir, ctrl.ext_dir_en, ud_s);

   // prescale limit, 4 when fast, else base 8 shifted by input select
   // one prescaler for timer and gated modes
   always_comb begin
      presc_last = ((cgpt_pkg::PRESC_W)'(1) << (ctrl.fast ? cgpt_pkg::BASE_FAST_SHIFT
                    : (cgpt_pkg::BASE_NORM_SHIFT + int'(ctrl.isel)))) - (cgpt_pkg::PRESC_W)'(1);
   end

   // gate polarity from mode bit 0
   // gate only enables counting, no event output
   assign gate_ok = ctrl.mode[0] ? in_s : ~in_s;

   always_comb begin
      case (ctrl.isel)
         cgpt_pkg::EDGE_RISE: edge_hit = in_s & ~in_prev;
         cgpt_pkg::EDGE_FALL: edge_hit = ~in_s & in_prev;
         cgpt_pkg::EDGE_BOTH: edge_hit = in_s ^ in_prev;
         default: edge_hit = 1'b0; // None and reserved codes
      endcase
   end

   // Prescaler and step decision
   always_comb begin
      next_presc = cgpt_pkg::PRESC_RST;
      tick = 1'b0;
      step = 1'b0;
      case (ctrl.mode)
         cgpt_pkg::MODE_TIMER: begin
            if (ctrl.run) begin
               tick = (presc >= presc_last);
               next_presc = tick ? cgpt_pkg::PRESC_RST : presc + (cgpt_pkg::PRESC_W)'(1);
            end
            step = tick;
         end
         cgpt_pkg::MODE_GATED_LO, cgpt_pkg::MODE_GATED_HI: begin
            if (ctrl.run && gate_ok) begin
               tick = (presc >= presc_last);
               next_presc = tick ? cgpt_pkg::PRESC_RST : presc + (cgpt_pkg::PRESC_W)'(1);
            end else begin
               next_presc = presc; // Hold phase while gated off
            end
            step = tick;
         end
         // relies on held input levels for clean edges
         cgpt_pkg::MODE_COUNTER: step = ctrl.run && edge_hit;
         default: step = 1'b0;
      endcase
   end

   // wrap detection at all ones / zero
   assign wrap = step && (down ? (count == CNT_W'(0)) : (count == CNT_W'(cgpt_pkg::CNT_ONES)));

   // Counter and toggle latch next values
   always_comb begin
      next_count = count;
      next_toggle = toggle;
      if (cnt_wr.wr) begin
         next_count = cnt_wr.value[CNT_W-1:0];
      end else if (step) begin
         next_count = down ? count - CNT_W'(1) : count + CNT_W'(1);
      end
      if (tog_wr) begin
         next_toggle = tog_wr_val;
      end else if (wrap && !cnt_wr.wr) begin
         next_toggle = ~toggle;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc <= cgpt_pkg::PRESC_RST;
         count <= CNT_W'(cgpt_pkg::CNT_RST);
         toggle <= cgpt_pkg::TOGGLE_RST;
      end else begin
         presc <= next_presc;
         count <= next_count;
         toggle <= next_toggle;
      end
   end

   assign toggle_output_line = ctrl.tog_oe & toggle;
   // internal link, not gated by output enable
   assign aux_toggle_link = toggle;
   assign first_aux_run = first_aux_remote_run & ctrl.run;
   assign second_aux_run = second_aux_remote_run & ctrl.run;

   // One driver for the whole status carrier; a write in the wrap cycle hides the overflow
   assign stat = '{count_down: down,
                   overflow: wrap & ~cnt_wr.wr,
                   toggle: toggle};

   // Checks
   chk_dir_sense: assert property (@(posedge clk) disable iff (sys_rst)
      down == (ctrl.ext_dir_en ? (sync_b[1] ^ ctrl.sw_dir) : ctrl.sw_dir))
      else $error("direction mismatch");
   chk_wrap_toggle: assert property (@(posedge clk) disable iff (sys_rst)
      (wrap && !cnt_wr.wr && !tog_wr) |=> (toggle != $past(toggle)))
      else $error("wrap did not toggle latch");
   chk_sw_toggle: assert property (@(posedge clk) disable iff (sys_rst)
      tog_wr |=> (toggle == $past(tog_wr_val)))
      else $error("toggle write lost");
   chk_out_gate: assert property (@(posedge clk) disable iff (sys_rst)
      !ctrl.tog_oe |-> !toggle_output_line)
      else $error("toggle output driven while disabled");
   chk_cpu_wins: assert property (@(posedge clk) disable iff (sys_rst)
      cnt_wr.wr |=> (count == $past(cnt_wr.value)))
      else $error("cpu write lost");
   chk_gate_halt: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl.mode[2:1] == 2'h1 && (!ctrl.run || !gate_ok) && !cnt_wr.wr) |=> $stable(count))
      else $error("gated timer advanced");
   chk_run_stop: assert property (@(posedge clk) disable iff (sys_rst)
      (!ctrl.run && !cnt_wr.wr) |=> $stable(count))
      else $error("stopped timer advanced");
   chk_edge_none: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl.mode == cgpt_pkg::MODE_COUNTER && ctrl.isel[1:0] == 2'h0 && !cnt_wr.wr) |=> $stable(count))
      else $error("counter moved with no edge select");
   chk_fast_rate: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl.mode == cgpt_pkg::MODE_TIMER && ctrl.run && ctrl.fast && tick) |-> ##1 !tick ##1 !tick ##1 !tick)
      else $error("fastest prescale wrong");
   cov_wrap: cover property (@(posedge clk) disable iff (sys_rst) wrap);
   cov_edge: cover property (@(posedge clk) disable iff (sys_rst) ctrl.mode == cgpt_pkg::MODE_COUNTER && step);
   cov_gated: cover property (@(posedge clk) disable iff (sys_rst) ctrl.mode == cgpt_pkg::MODE_GATED_HI && step);
endmodule

// *** rtl/cgpt_pkg.sv ***
/*
 Package for the core general purpose timer: mode codes, edge selects,
 prescale constants, reset values and the control/status carriers.
 Assumes a single 100 MHz module clock shared by all users.
*/
package cgpt_pkg;
   localparam int CNT_W = 16;
   localparam int MODE_W = 3;
   localparam int ISEL_W = 3;
   localparam int BPS_W = 2;
   // Mode field codes
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_COUNTER = 3'h1;
   localparam logic [2:0] MODE_GATED_LO = 3'h2;
   localparam logic [2:0] MODE_GATED_HI = 3'h3;
   // Counter mode edge selects
   localparam logic [2:0] EDGE_NONE = 3'h0;
   localparam logic [2:0] EDGE_RISE = 3'h1;
   localparam logic [2:0] EDGE_FALL = 3'h2;
   localparam logic [2:0] EDGE_BOTH = 3'h3;
   // Base prescale: fastest flag gives 4, otherwise 8
   localparam int BASE_FAST_SHIFT = 2;
   localparam int BASE_NORM_SHIFT = 3;
   localparam int PRESC_W = 11;
   // Reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [10:0] PRESC_RST = 11'h000;
   localparam logic TOGGLE_RST = 1'b0;
   localparam logic [2:0] SYNC_RST = 3'h0;
   localparam logic [15:0] CNT_ONES = 16'hFFFF;
   // Least hold of the count input, in module clock cycles
   localparam int IN_HOLD_CYC = 4;

   typedef struct packed {
      logic run;
      logic [2:0] mode;
      logic [2:0] isel;
      logic fast;
      logic sw_dir;
      logic ext_dir_en;
      logic tog_oe;
   } cgpt_ctrl_t;

   typedef struct packed {
      logic [15:0] value;
      logic wr;
   } cgpt_wr_t;

   typedef struct packed {
      logic count_down;
      logic overflow;
      logic toggle;
   } cgpt_stat_t;
endpackage

// *** sim/cgpt_ext_src.sv ***
/*
 Far-side model driving the gate/count line and the up/down line.
 Assumes the bench calls its tasks in step with the shared clock.
*/
`timescale 1ns/1ns
module cgpt_ext_src (
   // Clock
   input wire logic clk,
   // Lines into the timer
   output logic timer_input_line,
   output logic ext_updown_line
);
   // Quiet levels from time zero
   initial begin
      timer_input_line = 1'b0;
      ext_updown_line = 1'b0;
   end
   // hold each level
   // Extra edge of hold covers the two-flop synchroniser too
   task automatic put_in(input logic v);
      @(posedge clk) #1 timer_input_line = v;
      repeat (cgpt_pkg::IN_HOLD_CYC + 1) @(posedge clk);
      // Return off the edge so the caller reads settled outputs
      #1;
   endtask
   task automatic put_ud(input logic v);
      @(posedge clk) #1 ext_updown_line = v;
      repeat (cgpt_pkg::IN_HOLD_CYC + 1) @(posedge clk);
      #1;
   endtask
endmodule

// *** sim/tb.sv ***
/*
 Self-checking bench for the core timer: prescale, direction, wrap,
 gating, edge counting, write priority and remote run.
 Assumes the far-side model drives the two external lines.
*/
`timescale 1ns/1ns
module tb;
   logic clk, sys_rst, tog_wr, tog_wr_val, rr1, rr2, tol, atl, far, sar;
   cgpt_pkg::cgpt_ctrl_t ctrl;
   cgpt_pkg::cgpt_wr_t cnt_wr;
   cgpt_pkg::cgpt_stat_t stat;
   logic [15:0] count;
   wire tin, tud;
   int miscompares = 0, num_checks = 0, cycles = 0;
   cgpt_core_timer u_cgpt_core_timer (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .cnt_wr(cnt_wr),
      .tog_wr(tog_wr), .tog_wr_val(tog_wr_val), .timer_input_line(tin), .ext_updown_line(tud),
      .first_aux_remote_run(rr1), .second_aux_remote_run(rr2), .count(count), .stat(stat),
      .toggle_output_line(tol), .aux_toggle_link(atl), .first_aux_run(far), .second_aux_run(sar));
   cgpt_ext_src u_cgpt_ext_src (.clk(clk), .timer_input_line(tin), .ext_updown_line(tud));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait for the next counter step; n is the gap in cycles
   task automatic wait_step(output int n);
      logic [15:0] c0;
      c0 = count;
      n = 0;
      while (count === c0 && n < 5000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic load(input logic [15:0] v);
      cnt_wr = '{value: v, wr: 1'b1};
      cyc(1);
      cnt_wr.wr = 1'b0;
      chk(count, v);
   endtask
   task automatic force_tog(input logic v);
      tog_wr = 1'b1;
      tog_wr_val = v;
      cyc(1);
      tog_wr = 1'b0;
      chk(16'(stat.toggle), 16'(v));
   endtask
   task automatic t_presc();
      int n;
      ctrl = '0;
      ctrl.run = 1'b1;
      ctrl.fast = 1'b1;
      wait_step(n);
      wait_step(n);
      chk(16'(n), 16'h0004);
      ctrl.fast = 1'b0;
      // Rising factors only, so a shorter period never strands the prescaler
      for (int i = 0; i < 8; i++) begin
         ctrl.isel = 3'(i);
         load(16'h1234);
         wait_step(n);
         wait_step(n);
         chk(16'(n), 16'h0008 << i);
      end
      $display("t_presc done");
   endtask
   task automatic t_dir();
      int n;
      logic [15:0] c;
      logic dn;
      ctrl = '0;
      ctrl.run = 1'b1;
      ctrl.fast = 1'b1;
      for (int k = 0; k < 8; k++) begin
         ctrl.ext_dir_en = k[2];
         ctrl.sw_dir = k[1];
         dn = k[2] ? (k[0] ^ k[1]) : k[1];
         u_cgpt_ext_src.put_ud(k[0]);
         chk(16'(stat.count_down), 16'(dn));
         wait_step(n);
         c = count;
         wait_step(n);
         chk(count, dn ? c - 16'h0001 : c + 16'h0001);
      end
      u_cgpt_ext_src.put_ud(1'b0);
      $display("t_dir done");
   endtask
   task automatic t_wrap();
      int n;
      ctrl = '0;
      ctrl.run = 1'b1;
      ctrl.fast = 1'b1;
      ctrl.tog_oe = 1'b1;
      force_tog(1'b0);
      load(16'hFFFF);
      // Overflow flag stands only in the wrap cycle, so catch it there
      n = 0;
      while (stat.overflow !== 1'b1 && n < 16) begin
         cyc(1);
         n++;
      end
      chk(16'(stat.overflow), 16'h0001);
      chk(count, 16'hFFFF);
      cyc(1);
      chk(count, 16'h0000);
      chk(16'(stat.overflow), 16'h0000);
      chk({13'h0, stat.toggle, tol, atl}, 16'h0007);
      ctrl.sw_dir = 1'b1;
      load(16'h0000);
      wait_step(n);
      chk(count, 16'hFFFF);
      chk(16'(stat.toggle), 16'h0000);
      ctrl.tog_oe = 1'b0;
      force_tog(1'b1);
      chk({14'h0, tol, atl}, 16'h0001);
      $display("t_wrap done");
   endtask
   task automatic t_gate();
      int n;
      logic [15:0] c;
      for (int m = 2; m < 4; m++) begin
         ctrl = '0;
         ctrl.mode = 3'(m);
         ctrl.fast = 1'b1;
         ctrl.run = 1'b1;
         u_cgpt_ext_src.put_in(m == 2);
         c = count;
         cyc(40);
         chk(count, c);
         u_cgpt_ext_src.put_in(m != 2);
         cyc(20);
         chk(16'(count === c), 16'h0000);
         // Gated counting keeps the timer-mode prescale
         wait_step(n);
         wait_step(n);
         chk(16'(n), 16'h0004);
         ctrl.run = 1'b0;
         cyc(3);
         c = count;
         cyc(40);
         chk(count, c);
      end
      $display("t_gate done");
   endtask
   task automatic t_edges();
      ctrl = '0;
      ctrl.mode = cgpt_pkg::MODE_COUNTER;
      ctrl.run = 1'b1;
      u_cgpt_ext_src.put_in(1'b0);
      // Codes 0 to 3 plus the first reserved code
      for (int e = 0; e < 5; e++) begin
         ctrl.isel = 3'(e);
         load(16'h0010);
         u_cgpt_ext_src.put_in(1'b1);
         u_cgpt_ext_src.put_in(1'b0);
         chk(count, 16'h0010 + 16'(e == 1 || e == 3) + 16'(e == 2 || e == 3));
      end
      $display("t_edges done");
   endtask
   task automatic t_remote();
      for (int k = 0; k < 8; k++) begin
         {ctrl.run, rr1, rr2} = 3'(k);
         cyc(1);
         chk({14'h0, far, sar}, {14'h0, k[2] & k[1], k[2] & k[0]});
      end
      $display("t_remote done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      ctrl = '0;
      cnt_wr = '0;
      tog_wr = 1'b0;
      tog_wr_val = 1'b0;
      rr1 = 1'b0;
      rr2 = 1'b0;
      cyc(6);
      chk(count, cgpt_pkg::CNT_RST);
      chk({14'h0, stat.toggle, atl}, {14'h0, cgpt_pkg::TOGGLE_RST, cgpt_pkg::TOGGLE_RST});
      sys_rst = 1'b0;
      t_presc();
      t_dir();
      t_wrap();
      t_gate();
      t_edges();
      t_remote();
      tally_and_finish();
   end
endmodule
